// ==== hdl/irq_prio_pkg.sv ====
package irq_prio_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  // The printed offsets are not multiples of four, so they are indexes.
  localparam logic [7:0] IDX_PRIO_0_3 = 8'h2C;
  localparam logic [7:0] IDX_PRIO_4_7 = 8'h2D;
  localparam logic [7:0] IDX_PRIO_8_11 = 8'h2E;
  localparam logic [7:0] IDX_PRIO_12_13 = 8'h2F;
  localparam logic [7:0] IDX_FLAGS = 8'h30;
  localparam logic [7:0] IDX_STATUS = 8'h31;
  localparam logic [7:0] IDX_ENABLE_LO = 8'h32;
  localparam logic [7:0] IDX_ENABLE_HI = 8'h33;
  localparam logic [7:0] IDX_EDGE_LO = 8'h34;
  localparam logic [7:0] IDX_EDGE_HI = 8'h35;
  localparam logic [7:0] IDX_PEND_LO = 8'h36;
  localparam logic [7:0] IDX_PEND_HI = 8'h37;
  localparam int ADDR_LSB = 2;

  // ----------------------------------------------------------------------
  // Reset values and fields
  // ----------------------------------------------------------------------
  localparam logic [7:0] PRIO_RESET = 8'hFF;
  localparam logic [7:0] PRIO3_RO_MASK = 8'hF0;
  localparam logic [7:0] FLAGS_RESET = 8'hEA;
  localparam int FLAG_HI_POS = 5;
  localparam int FLAG_LO_POS = 3;

  // ----------------------------------------------------------------------
  // Priority level codes (high bit, low bit)
  // ----------------------------------------------------------------------
  localparam logic [1:0] LVL0 = 2'b10;
  localparam logic [1:0] LVL1 = 2'b01;
  localparam logic [1:0] LVL2 = 2'b00;
  localparam logic [1:0] LVL3 = 2'b11;

  // ----------------------------------------------------------------------
  // Vectors
  // ----------------------------------------------------------------------
  localparam int NUM_SRC = 14;
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP = 16'hFFFC;
  localparam logic [15:0] VEC_TOP = 16'hFFFA;
  // Sources 1..13 that may end halt: plug, port A, suspend end, port D, port C, SPI.
  localparam logic [13:0] HALT_WAKE_MASK = 14'h0666;

  typedef enum logic [2:0] {
    CPU_NONE, CPU_ENABLE, CPU_DISABLE, CPU_HALT, CPU_WAIT, CPU_RETURN, CPU_POP, CPU_TRAP
  } cpu_op_e;

  typedef struct packed {
    logic take;
    logic [3:0] index;
    logic [1:0] level;
    logic [15:0] vector;
    logic fixed_kind;
  } irq_req_s;

endpackage

// ==== hdl/nested_irq_priority_ctrl.sv ====
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
module nested_irq_priority_ctrl #(
  parameter int NSRC = irq_prio_pkg::NUM_SRC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Interrupt sources
  input wire logic [NSRC-1:0] src_req_i,
  input wire logic trap_i,
  input wire logic halted_i,
  // CPU core side
  input wire logic cpu_ack_i,
  input wire logic [2:0] cpu_op_i,
  input wire logic [7:0] cpu_pop_flags_i,
  output irq_prio_pkg::irq_req_s irq_req_o,
  output logic [7:0] flags_o
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [NSRC-1:0] src_meta;
  logic [NSRC-1:0] src_sync;
  logic [NSRC-1:0] src_prev;
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      src_meta <= '0;
      src_sync <= '0;
      src_prev <= '0;
    end else begin
      src_meta <= src_req_i;
      src_sync <= src_meta;
      src_prev <= src_sync;
    end
  end

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Maps the level code onto a plain rank 0..3.
  function automatic logic [1:0] rank(input logic [1:0] code);
    case (code)
      irq_prio_pkg::LVL0: rank = 2'd0;
      irq_prio_pkg::LVL1: rank = 2'd1;
      irq_prio_pkg::LVL2: rank = 2'd2;
      default: rank = 2'd3;
    endcase
  endfunction

  // Merges one byte into a priority register, keeping pairs written as level 0.
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wr);
    logic [7:0] res;
    res = old;
    for (int p = 0; p < 4; p++) begin
      if (wr[2*p+:2] != irq_prio_pkg::LVL0) begin
        res[2*p+:2] = wr[2*p+:2];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0] prio [4];
  logic [7:0] flags;
  logic [NSRC-1:0] enable;
  logic [NSRC-1:0] edge_mode;
  logic [NSRC-1:0] latch;
  logic [1:0] svc_level;
  logic [3:0] svc_index;
  logic in_svc;
  logic ack_q;
  logic [31:0] rd_q;
  irq_prio_pkg::irq_req_s req_q;
  logic [7:0] next_prio [4];
  logic [7:0] next_flags;
  logic [NSRC-1:0] next_enable;
  logic [NSRC-1:0] next_edge_mode;
  logic [NSRC-1:0] next_latch;
  logic [1:0] next_svc_level;
  logic [3:0] next_svc_index;
  logic next_in_svc;
  logic next_ack;
  logic [31:0] next_rd;
  irq_prio_pkg::irq_req_s next_req;

  logic wb_hit;
  logic wb_wr;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic [NSRC-1:0] pending;
  logic [1:0] cur_rank;
  logic [1:0] best_rank;
  logic [3:0] best_idx;
  logic best_found;
  irq_prio_pkg::irq_req_s cand;

  localparam int ADDR_LSB = irq_prio_pkg::ADDR_LSB;
  assign wb_hit = wb_cyc_i && wb_stb_i && !ack_q;
  // A write lands at the edge where the master sees ack, while its request still stands.
  assign wb_wr = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0];
  assign idx = {2'b00, wb_adr_i[7:ADDR_LSB]};
  assign wbyte = wb_dat_i[7:0];

  // ----------------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------------
  always_comb begin
    pending = latch & enable;
    cur_rank = rank({flags[irq_prio_pkg::FLAG_HI_POS], flags[irq_prio_pkg::FLAG_LO_POS]});
    best_found = 1'b0;
    best_rank = 2'd0;
    best_idx = 4'd0;
    cand = '0;
    for (int n = NSRC - 1; n >= 1; n--) begin
      if (pending[n] && (rank(prio[n/4][2*(n%4)+:2]) > cur_rank)
          && (!halted_i || irq_prio_pkg::HALT_WAKE_MASK[n])
          && (!best_found || rank(prio[n/4][2*(n%4)+:2]) >= best_rank)) begin
        best_found = 1'b1;
        best_rank = rank(prio[n/4][2*(n%4)+:2]);
        best_idx = 4'(n);
      end
    end
    if (trap_i && !halted_i) begin
      cand.take = 1'b1;
      cand.fixed_kind = 1'b1;
      cand.level = irq_prio_pkg::LVL3;
      cand.vector = irq_prio_pkg::VEC_TRAP;
    end else if (latch[0]) begin
      cand.take = 1'b1;
      cand.fixed_kind = 1'b1;
      cand.level = irq_prio_pkg::LVL3;
      cand.vector = irq_prio_pkg::VEC_TOP;
    end else if (best_found) begin
      cand.take = 1'b1;
      cand.index = best_idx;
      cand.level = prio[best_idx/4][2*(best_idx%4)+:2];
      cand.vector = 16'(irq_prio_pkg::VEC_TOP - 16'(2 * best_idx));
    end
  end

  // ----------------------------------------------------------------------
  // State update
  // ----------------------------------------------------------------------
  always_comb begin
    for (int r = 0; r < 4; r++) begin
      next_prio[r] = prio[r];
    end
    next_flags = flags;
    next_enable = enable;
    next_edge_mode = edge_mode;
    next_latch = latch;
    next_svc_level = svc_level;
    next_svc_index = svc_index;
    next_in_svc = in_svc;
    next_ack = wb_hit;
    next_rd = 32'h0000_0000;
    next_req = cand;
    // Bus writes.
    if (wb_wr) begin
      case (idx)
        irq_prio_pkg::IDX_PRIO_0_3: next_prio[0] = merge(prio[0], wbyte);
        irq_prio_pkg::IDX_PRIO_4_7: next_prio[1] = merge(prio[1], wbyte);
        irq_prio_pkg::IDX_PRIO_8_11: next_prio[2] = merge(prio[2], wbyte);
        irq_prio_pkg::IDX_PRIO_12_13:
          next_prio[3] = merge(prio[3], wbyte) | irq_prio_pkg::PRIO3_RO_MASK;
        irq_prio_pkg::IDX_ENABLE_LO: next_enable[7:0] = wbyte;
        irq_prio_pkg::IDX_ENABLE_HI: next_enable[NSRC-1:8] = wbyte[NSRC-9:0];
        irq_prio_pkg::IDX_EDGE_LO: next_edge_mode[7:0] = wbyte;
        irq_prio_pkg::IDX_EDGE_HI: next_edge_mode[NSRC-1:8] = wbyte[NSRC-9:0];
        default: ;
      endcase
    end
    // Bus reads; unmapped indexes read zero.
    if (wb_hit && !wb_we_i) begin
      case (idx)
        irq_prio_pkg::IDX_PRIO_0_3: next_rd[7:0] = prio[0];
        irq_prio_pkg::IDX_PRIO_4_7: next_rd[7:0] = prio[1];
        irq_prio_pkg::IDX_PRIO_8_11: next_rd[7:0] = prio[2];
        irq_prio_pkg::IDX_PRIO_12_13: next_rd[7:0] = prio[3];
        irq_prio_pkg::IDX_FLAGS: next_rd[7:0] = flags;
        irq_prio_pkg::IDX_STATUS: next_rd[7:0] = {in_svc, svc_index, 1'b0, svc_level};
        irq_prio_pkg::IDX_ENABLE_LO: next_rd[7:0] = enable[7:0];
        irq_prio_pkg::IDX_ENABLE_HI: next_rd[NSRC-9:0] = enable[NSRC-1:8];
        irq_prio_pkg::IDX_EDGE_LO: next_rd[7:0] = edge_mode[7:0];
        irq_prio_pkg::IDX_EDGE_HI: next_rd[NSRC-9:0] = edge_mode[NSRC-1:8];
        irq_prio_pkg::IDX_PEND_LO: next_rd[7:0] = latch[7:0];
        irq_prio_pkg::IDX_PEND_HI: next_rd[NSRC-9:0] = latch[NSRC-1:8];
        default: ;
      endcase
    end
    // CPU instructions acting on the level.
    // instruction levels
    case (irq_prio_pkg::cpu_op_e'(cpu_op_i))
      irq_prio_pkg::CPU_ENABLE, irq_prio_pkg::CPU_HALT, irq_prio_pkg::CPU_WAIT: begin
        next_flags[irq_prio_pkg::FLAG_HI_POS] = irq_prio_pkg::LVL0[1];
        next_flags[irq_prio_pkg::FLAG_LO_POS] = irq_prio_pkg::LVL0[0];
      end
      irq_prio_pkg::CPU_DISABLE, irq_prio_pkg::CPU_TRAP: begin
        next_flags[irq_prio_pkg::FLAG_HI_POS] = irq_prio_pkg::LVL3[1];
        next_flags[irq_prio_pkg::FLAG_LO_POS] = irq_prio_pkg::LVL3[0];
      end
      irq_prio_pkg::CPU_RETURN, irq_prio_pkg::CPU_POP: begin
        next_flags = cpu_pop_flags_i;
        if (irq_prio_pkg::cpu_op_e'(cpu_op_i) == irq_prio_pkg::CPU_RETURN) begin
          next_in_svc = 1'b0;
        end
      end
      default: ;
    endcase
    // Service entry on CPU acknowledge at an instruction boundary.
    // acknowledge clears the top and edge-mode latches
    if (cpu_ack_i && req_q.take) begin
      next_flags[irq_prio_pkg::FLAG_HI_POS] = req_q.level[1];
      next_flags[irq_prio_pkg::FLAG_LO_POS] = req_q.level[0];
      next_svc_level = req_q.level;
      next_svc_index = req_q.index;
      next_in_svc = 1'b1;
      if (req_q.vector == irq_prio_pkg::VEC_TOP) begin
        next_latch[0] = 1'b0;
      end else if (!req_q.fixed_kind && edge_mode[req_q.index]) begin
        next_latch[req_q.index] = 1'b0;
      end
    end
    // Request capture wins over the clear in the same cycle.
    for (int n = 0; n < NSRC; n++) begin
      if (edge_mode[n] || n == 0) begin
        if (src_sync[n] && !src_prev[n]) begin
          next_latch[n] = 1'b1;
        end
      end else begin
        next_latch[n] = src_sync[n];
      end
    end
    // re-entry on raised level
    // A rewritten pair only matters through arbitration, which already compares
    // the new stored level against the current one, so a pending raise re-enters.
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int r = 0; r < 4; r++) begin
        prio[r] <= irq_prio_pkg::PRIO_RESET;
      end
      flags <= irq_prio_pkg::FLAGS_RESET;
      enable <= '0;
      edge_mode <= '0;
      latch <= '0;
      svc_level <= irq_prio_pkg::LVL3;
      svc_index <= 4'd0;
      in_svc <= 1'b0;
      ack_q <= 1'b0;
      rd_q <= 32'h0000_0000;
      req_q <= '0;
    end else begin
      for (int r = 0; r < 4; r++) begin
        prio[r] <= next_prio[r];
      end
      flags <= next_flags;
      enable <= next_enable;
      edge_mode <= next_edge_mode;
      latch <= next_latch;
      svc_level <= next_svc_level;
      svc_index <= next_svc_index;
      in_svc <= next_in_svc;
      ack_q <= next_ack;
      rd_q <= next_rd;
      req_q <= next_req;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rd_q;
  assign irq_req_o = req_q;
  assign flags_o = flags;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n);

  AST_ACK_ONE: assert property (wb_hit |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle");
  AST_TOP_NIBBLE: assert property (prio[3][7:4] == 4'hF)
    else $error("read-only nibble changed");
  AST_LVL0_KEEP: assert property (wb_wr && idx == irq_prio_pkg::IDX_PRIO_0_3
      && wbyte[1:0] == irq_prio_pkg::LVL0 |=> prio[0][1:0] == $past(prio[0][1:0]))
    else $error("level 0 write changed a pair");
  AST_ENTRY_LEVEL: assert property (cpu_ack_i && req_q.take
      |=> {flags[5], flags[3]} == $past(req_q.level))
    else $error("entry did not load the level");
  AST_FIXED_L3: assert property (req_q.take && req_q.fixed_kind |-> req_q.level == 2'b11)
    else $error("fixed vector without level 3");
  AST_ENABLE_L0: assert property (cpu_op_i == 3'd1 && !(cpu_ack_i && req_q.take)
      |=> {flags[5], flags[3]} == 2'b10)
    else $error("enable did not load level 0");
  AST_TOP_VEC: assert property ($rose(latch[0]) |=> req_q.take
      && (req_q.vector == 16'hFFFA || req_q.vector == 16'hFFFC))
    else $error("top interrupt not offered");
  AST_MASK_STRICT: assert property (req_q.take && !req_q.fixed_kind
      |-> rank(req_q.level) > rank({$past(flags[5]), $past(flags[3])}))
    else $error("maskable taken without higher level");
  COV_NEST: cover property (req_q.take && !req_q.fixed_kind ##[1:20] in_svc && req_q.take);
  COV_TOP: cover property (req_q.take && req_q.vector == 16'hFFFA);
  COV_RET: cover property (in_svc ##1 !in_svc);

endmodule // nested_irq_priority_ctrl

// ==== verif/cpu_core_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// CPU core stand-in
// ----------------------------------------------------------------------
// It acks an offer after a set stall, stacks the flags and hands them back.
module cpu_core_model (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Bench commands
  input wire logic accept_i,
  input wire logic [3:0] stall_i,
  input wire logic [2:0] op_cmd_i,
  input wire logic [7:0] pop_val_i,
  // Controller side
  input wire irq_prio_pkg::irq_req_s req_i,
  input wire logic [7:0] flags_i,
  output logic ack_o,
  output logic [2:0] op_o,
  output logic [7:0] pop_o,
  // Record of entries: the last vector and the entry count
  output logic [15:0] vector_o,
  output logic [15:0] count_o
);
  logic [7:0] stack [$];
  logic [3:0] seen;
  logic [3:0] holdoff;

  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_o <= 1'b0;
      op_o <= 3'h0;
      pop_o <= 8'h00;
      vector_o <= 16'h0000;
      count_o <= 16'h0000;
      seen <= 4'h0;
      holdoff <= 4'h0;
    end else begin
      ack_o <= 1'b0;
      op_o <= op_cmd_i;
      seen <= (accept_i && req_i.take) ? seen + 4'h1 : 4'h0;
      if (holdoff != 4'h0) begin
        holdoff <= holdoff - 4'h1;
      end
      // The offer lags its cause, so a holdoff keeps one entry from being acked twice.
      // ack at boundary
      if (accept_i && req_i.take && holdoff == 4'h0 && seen >= stall_i) begin
        ack_o <= 1'b1;
        vector_o <= req_i.vector;
        count_o <= count_o + 16'h0001;
        holdoff <= 4'h8;
        stack.push_back(flags_i);
      end
      if (op_cmd_i == irq_prio_pkg::CPU_RETURN && stack.size() != 0) begin
        pop_o <= stack.pop_back();
      end
      if (op_cmd_i == irq_prio_pkg::CPU_POP) begin
        pop_o <= pop_val_i;
      end
    end
  end
endmodule // cpu_core_model

// ==== verif/nested_irq_priority_ctrl_tb.sv ====
`timescale 1ns/1ps
module nested_irq_priority_ctrl_tb;
  localparam logic [1:0] L0 = irq_prio_pkg::LVL0;
  localparam logic [1:0] L1 = irq_prio_pkg::LVL1;
  localparam logic [1:0] L2 = irq_prio_pkg::LVL2;
  localparam logic [1:0] L3 = irq_prio_pkg::LVL3;
  localparam logic [2:0] RET = irq_prio_pkg::CPU_RETURN;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0000_0000;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic [13:0] src_req = 14'h0000;
  logic trap = 1'b0;
  logic halted = 1'b0;
  logic accept = 1'b0;
  logic [3:0] stall = 4'h0;
  logic [2:0] op_cmd = 3'h0;
  logic [7:0] pop_val = 8'hC2;
  logic cpu_ack;
  logic [2:0] cpu_op;
  logic [7:0] pop_flags;
  logic [7:0] flags;
  logic [15:0] tk_vec;
  logic [15:0] tk_count;
  logic [7:0] rd;
  irq_prio_pkg::irq_req_s irq_req;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  logic [2:0] ops [6] = '{irq_prio_pkg::CPU_ENABLE, irq_prio_pkg::CPU_DISABLE,
    irq_prio_pkg::CPU_HALT, irq_prio_pkg::CPU_TRAP, irq_prio_pkg::CPU_WAIT, irq_prio_pkg::CPU_POP};
  logic [1:0] lvls [6] = '{L0, L3, L0, L3, L0, L2};

  always #12.5 clk_sys_i = ~clk_sys_i;

  nested_irq_priority_ctrl dut (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'h1), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .src_req_i(src_req), .trap_i(trap),
    .halted_i(halted), .cpu_ack_i(cpu_ack), .cpu_op_i(cpu_op),
    .cpu_pop_flags_i(pop_flags), .irq_req_o(irq_req), .flags_o(flags));

  cpu_core_model cpu (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .accept_i(accept), .stall_i(stall),
    .op_cmd_i(op_cmd), .pop_val_i(pop_val), .req_i(irq_req), .flags_i(flags),
    .ack_o(cpu_ack), .op_o(cpu_op), .pop_o(pop_flags), .vector_o(tk_vec),
    .count_o(tk_count));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic final_report();
    if (failures == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Entered just after a rising edge; the request holds until ack is sampled.
  task automatic wb_xfer(input logic we, input logic [7:0] idx, input logic [7:0] wdat);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {idx[5:0], 2'b00};
    wb_wdat <= {24'h00_0000, wdat};
    do begin
      @(posedge clk_sys_i);
    end while (wb_ack !== 1'b1);
    rd = wb_rdat[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    wb_xfer(1'b1, idx, d);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    wb_xfer(1'b0, idx, 8'h00);
    chk_byte(rd, exp, "register");
  endtask

  task automatic do_op(input logic [2:0] op);
    op_cmd <= op;
    @(posedge clk_sys_i);
    op_cmd <= irq_prio_pkg::CPU_NONE;
    repeat (5) @(posedge clk_sys_i);
  endtask

  task automatic chk_lvl(input logic [1:0] l);
    chk_byte(flags & 8'h28, {2'b00, l[1], 1'b0, l[0], 3'b000}, "level");
  endtask

  function automatic logic [15:0] vec(input int n);
    return 16'hFFFA - 16'(2 * n);
  endfunction

  task automatic expect_irq(input logic [15:0] v, input logic [1:0] l);
    logic [15:0] c0;
    int n;
    c0 = tk_count;
    n = 0;
    while (tk_count === c0 && n < 60) begin
      @(posedge clk_sys_i);
      n++;
    end
    trap <= 1'b0;
    src_req[0] <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    chk_vec(tk_count, c0 + 16'h0001, "entries");
    chk_vec(tk_vec, v, "vector");
    chk_lvl(l);
  endtask

  task automatic expect_none(input int n);
    logic [15:0] c0;
    c0 = tk_count;
    repeat (n) @(posedge clk_sys_i);
    chk_vec(tk_count, c0, "entries");
  endtask

  // The whole sequence takes about 300 cycles.
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      failures++;
      $display("BAD %0t timeout", $time);
      final_report();
    end
  end

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    chk_byte(flags & 8'hEF, 8'hEA, "flags reset");
    for (int i = 0; i < 4; i++) begin
      rd_chk(8'h2C + 8'(i), 8'hFF);
    end
    wr(8'h2F, 8'h00);
    rd_chk(8'h2F, 8'hF0);
    wr(8'h2C, 8'hCF);
    wr(8'h2C, 8'h64);
    rd_chk(8'h2C, 8'h44);
    wr(8'h3F, 8'h12);
    rd_chk(8'h3F, 8'h00);
    for (int i = 0; i < 6; i++) begin
      do_op(ops[i]);
      chk_lvl(lvls[i]);
    end
    do_op(irq_prio_pkg::CPU_ENABLE);
    wr(8'h2D, 8'hF1);
    wr(8'h32, 8'h3C);
    stall <= 4'h5;
    accept <= 1'b1;
    src_req[4:2] <= 3'b111;
    expect_irq(vec(2), L2);
    expect_none(20);
    accept <= 1'b0;
    src_req[2] <= 1'b0;
    do_op(RET);
    chk_lvl(L0);
    chk_vec(irq_req.vector, vec(3), "offer");
    stall <= 4'h0;
    accept <= 1'b1;
    expect_irq(vec(3), L1);
    wr(8'h2C, 8'h04);
    expect_irq(vec(3), L2);
    accept <= 1'b0;
    src_req[4:2] <= 3'b000;
    do_op(RET);
    do_op(RET);
    chk_lvl(L0);
    do_op(irq_prio_pkg::CPU_DISABLE);
    accept <= 1'b1;
    src_req[2] <= 1'b1;
    expect_none(20);
    trap <= 1'b1;
    expect_irq(16'hFFFC, L3);
    wr(8'h2C, 8'hC5);
    src_req[0] <= 1'b1;
    expect_irq(16'hFFFA, L3);
    accept <= 1'b0;
    src_req[2] <= 1'b0;
    do_op(irq_prio_pkg::CPU_HALT);
    halted <= 1'b1;
    accept <= 1'b1;
    src_req[3] <= 1'b1;
    expect_none(20);
    src_req[2] <= 1'b1;
    expect_irq(vec(2), L2);
    halted <= 1'b0;
    accept <= 1'b0;
    src_req[3:2] <= 2'b00;
    wr(8'h34, 8'h02);
    rd_chk(8'h34, 8'h02);
    wr(8'h32, 8'h02);
    do_op(irq_prio_pkg::CPU_ENABLE);
    src_req[1] <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    src_req[1] <= 1'b0;
    rd_chk(8'h36, 8'h02);
    accept <= 1'b1;
    expect_irq(vec(1), L1);
    rd_chk(8'h36, 8'h00);
    rd_chk(8'h31, 8'h89);
    final_report();
  end
endmodule // nested_irq_priority_ctrl_tb
